// >>> pkg/stx_pkg.sv
// constants and types shared by the serial transmit input path
package stx_pkg;
    // three-level selects as two-bit codes
    localparam logic [1:0] SEL_LOW  = 2'h0;
    localparam logic [1:0] SEL_MID  = 2'h1;
    localparam logic [1:0] SEL_HIGH = 2'h2;

    localparam int CHAR_DIV   = 10;
    localparam int WSYNC_LEN  = 16;
    localparam int BUF_DEPTH  = 4;
    localparam int BUF_CENTER = 2;

    localparam logic [8:0] BIST_SEED = 9'h1FF;
    localparam logic [9:0] C07_POS   = 10'h079;
    localparam logic [9:0] C07_NEG   = 10'h386;
    localparam logic [7:0] K28_5_DAT = 8'hBC;
    localparam logic [4:0] K28_LOW5  = 5'h1C;

    // 6b and 4b code tables, running disparity negative, a/f at msb
    localparam logic [5:0] K28_6B  = 6'b001111;
    localparam logic [3:0] ALT7_4B = 4'b0111;
    localparam logic [31:0][5:0] ENC6_TBL = {
        6'b101011, 6'b011110, 6'b101110, 6'b001110,
        6'b110110, 6'b010110, 6'b100110, 6'b110011,
        6'b111010, 6'b011010, 6'b101010, 6'b001011,
        6'b110010, 6'b010011, 6'b100011, 6'b011011,
        6'b010111, 6'b011100, 6'b101100, 6'b001101,
        6'b110100, 6'b010101, 6'b100101, 6'b111001,
        6'b111000, 6'b011001, 6'b101001, 6'b110101,
        6'b110001, 6'b101101, 6'b011101, 6'b100111};
    localparam logic [7:0][3:0] ENC4_TBL = {
        4'b1110, 4'b0110, 4'b1010, 4'b1101,
        4'b1100, 4'b0101, 4'b1001, 4'b1011};

    // register map
    localparam logic [7:0] REG_CTRL   = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_CHAR   = 8'h08;
    localparam int CTRL_MODE_LO_LSB = 0;
    localparam int CTRL_MODE_HI_LSB = 2;
    localparam int CTRL_PAR_LSB     = 4;
    localparam int CTRL_CKSEL_LSB   = 6;
    localparam int CTRL_RATE_BIT    = 8;
    localparam int CTRL_BIST_BIT    = 9;
    localparam logic [9:0] CTRL_RESET = 10'h000;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    typedef struct packed {
        logic [7:0] txData;
        logic [1:0] txControlBits;
        logic       txParityBit;
        logic       specialCharSelect;
    } stx_char_s;

    typedef enum logic [2:0] {
        SRC_DATA    = 3'b000,
        SRC_FILL    = 3'b001,
        SRC_SPECIAL = 3'b010,
        SRC_VIOL    = 3'b011,
        SRC_BIST    = 3'b100,
        SRC_RAW     = 3'b101
    } stx_src_e;
endpackage

// >>> rtl/stx_tx_input_path.sv
// transmit input register, phase-align buffer, parity check and encoder
//
// The placing of the registers and the AXI4-Lite interface to the registers were decided locally.
`timescale 1ns/10ps
module stx_tx_input_path #(
    parameter int BUF_DEPTH_P = stx_pkg::BUF_DEPTH
) (
    // clock and reset
    input  wire logic              core_clk,
    input  wire logic              resetn,
    // register bus
    input  wire logic [7:0]        s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [7:0]        s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    // host character pins
    input  wire stx_pkg::stx_char_s txHostIn,
    input  wire logic              txInputClock,
    input  wire logic              alignBufferResetN,
    // line side
    output logic                   txErrorFlag,
    output logic                   serialOut,
    output logic [9:0]             txCharOut,
    output logic                   txCharStrobe
);
    import stx_pkg::*;

    localparam int PW = $clog2(BUF_DEPTH_P) + 1;

    function automatic logic [9:0] stxReverse(input logic [9:0] v);
        logic [9:0] r;
        r = '0;
        for (int i = 0; i < 10; i++)
            r[i] = v[9 - i];
        return r;
    endfunction

    // returns {running disparity after, character with bit a at bit 0}
    function automatic logic [10:0] stxEncode(input logic [7:0] d,
                                              input logic k,
                                              input logic rd);
        logic [5:0] s6;
        logic [5:0] c6;
        logic [3:0] s4;
        logic [3:0] c4;
        logic       rd1;
        logic       rd2;
        logic       alt;
        logic       bal6;
        logic       bal4;
        s6   = k ? K28_6B : ENC6_TBL[d[4:0]];
        bal6 = ($countones(s6) == 3);
        c6   = (rd && (!bal6 || d[4:0] == 5'h07)) ? ~s6 : s6;
        rd1  = bal6 ? rd : ~rd;
        alt  = (d[7:5] == 3'h7) && (k || (!rd1 && c6[1] && c6[0])
               || (rd1 && !c6[1] && !c6[0]));
        s4   = alt ? ALT7_4B : ENC4_TBL[d[7:5]];
        bal4 = ($countones(s4) == 2);
        // control codes flip a balanced 4b group on the negative side
        c4   = ((rd1 && (!bal4 || d[7:5] == 3'h3))
               || (k && !rd1 && bal4 && d[7:5] != 3'h3)) ? ~s4 : s4;
        rd2  = bal4 ? rd1 : ~rd1;
        return {rd2, stxReverse({c6, c4})};
    endfunction

    // odd parity: xor of the checked bits must be one
    function automatic logic stxParityOk(input stx_char_s c,
                                         input logic [1:0] sel,
                                         input logic encEn);
        logic full;
        logic dataOnly;
        full     = ^{c.txData, c.txControlBits, c.txParityBit};
        dataOnly = ^{c.txData, c.txParityBit};
        case (sel)
            SEL_LOW:  return 1'b1;
            SEL_MID:  return encEn ? dataOnly : full;
            SEL_HIGH: return full;
            default:  return 1'b1;
        endcase
    endfunction

    // reset and pin synchronisers
    logic rstS1, rstN;
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            rstS1 <= 1'b0;
            rstN  <= 1'b0;
        end
        else
        begin
            rstS1 <= 1'b1;
            rstN  <= rstS1;
        end
    end

    // data crosses with its clock; host holds it around each input edge
    stx_char_s hostS1, hostS2;
    logic      ckS1, ckS2, ckS3;
    logic      brS1, brS2, brS3;
    always_ff @(posedge core_clk or negedge rstN)
    begin
        if (!rstN)
        begin
            hostS1 <= '0;
            hostS2 <= '0;
            {ckS1, ckS2, ckS3} <= 3'h0;
            {brS1, brS2, brS3} <= 3'h0;
        end
        else
        begin
            hostS1 <= txHostIn;
            hostS2 <= hostS1;
            {ckS1, ckS2, ckS3} <= {txInputClock, ckS1, ckS2};
            {brS1, brS2, brS3} <= {alignBufferResetN, brS1, brS2};
        end
    end

    // control register fields
    logic [9:0] ctrl_r;
    logic [1:0] modeLo, modeHi, parSel, ckSel;
    logic       rateDouble, bistEn;
    assign modeLo     = ctrl_r[CTRL_MODE_LO_LSB +: 2];
    assign modeHi     = ctrl_r[CTRL_MODE_HI_LSB +: 2];
    assign parSel     = ctrl_r[CTRL_PAR_LSB +: 2];
    assign ckSel      = ctrl_r[CTRL_CKSEL_LSB +: 2];
    assign rateDouble = ctrl_r[CTRL_RATE_BIT];
    assign bistEn     = ctrl_r[CTRL_BIST_BIT];

    logic encEn, atomicMode, useBuf;
    assign encEn      = (modeHi != SEL_LOW);
    assign atomicMode = (modeHi == SEL_MID);
    assign useBuf     = (ckSel != SEL_LOW) || rateDouble;

    // character rate divider: one bit per core cycle
    logic [3:0] divCnt_r;
    logic       charTick;
    assign charTick = (divCnt_r == 4'(CHAR_DIV - 1));
    always_ff @(posedge core_clk or negedge rstN)
    begin
        if (!rstN)
            divCnt_r <= 4'h0;
        else
            divCnt_r <= charTick ? 4'h0 : divCnt_r + 4'h1;
    end

    // phase-align buffer
    stx_char_s         bufMem [BUF_DEPTH_P];
    logic [PW-1:0]     wp_r, rp_r, fill;
    logic              bufErr_r, bufHold, ckEdge, wsStart;
    stx_char_s         cur;
    assign fill    = wp_r - rp_r;
    assign bufHold = !brS2 && !brS3;
    assign ckEdge  = rateDouble ? (ckS2 ^ ckS3) : (ckS2 && !ckS3);
    assign cur     = useBuf ? bufMem[rp_r[PW-2:0]] : hostS2;

    // held reset fills every slot so no stale word is read after release
    always_ff @(posedge core_clk)
    begin
        if (bufHold)
        begin
            for (int i = 0; i < BUF_DEPTH_P; i++)
                bufMem[i] <= hostS2;
        end
        else if (useBuf && ckEdge)
            bufMem[wp_r[PW-2:0]] <= hostS2;
    end

    always_ff @(posedge core_clk or negedge rstN)
    begin
        if (!rstN)
        begin
            wp_r     <= PW'(BUF_CENTER);
            rp_r     <= '0;
            bufErr_r <= 1'b0;
        end
        else if (bufHold || (wsStart && bufErr_r))
        begin
            wp_r     <= PW'(BUF_CENTER);
            rp_r     <= '0;
            bufErr_r <= 1'b0;
        end
        else if (useBuf)
        begin
            // centred start leaves half the depth of slack either side
            if (ckEdge)
            begin
                wp_r <= wp_r + PW'(1);
                if (fill == PW'(BUF_DEPTH_P))
                    bufErr_r <= 1'b1;
            end
            if (charTick)
            begin
                rp_r <= rp_r + PW'(1);
                if (fill == '0 && !ckEdge)
                    bufErr_r <= 1'b1;
            end
        end
    end

    // character source selection
    logic [4:0] wsCnt_r;
    logic [8:0] lfsr_r;
    logic       rd_r;
    logic       wsBusy, wsReq, parOk;
    stx_src_e   src;
    assign wsBusy = (wsCnt_r != 5'h00);
    assign parOk  = stxParityOk(cur, parSel, encEn);

    always_comb
    begin
        wsReq = 1'b0;
        src   = SRC_DATA;
        if (encEn && cur.txControlBits[0])
        begin
            if (cur.txControlBits[1])
                wsReq = 1'b1;
            else if (modeLo == SEL_MID && cur.specialCharSelect)
                wsReq = 1'b1;
        end
        if (bufErr_r)
            src = SRC_VIOL;
        else if (bistEn)
            src = SRC_BIST;
        else if (wsBusy)
            src = SRC_FILL;                               // input ignored
        else if (!parOk)
            src = SRC_VIOL;
        else if (!encEn)
            src = SRC_RAW;
        else if (!cur.txControlBits[0])
            src = SRC_DATA;
        else if (wsReq)
            src = SRC_FILL;
        else if (modeLo == SEL_HIGH || cur.specialCharSelect)
            src = SRC_SPECIAL;
        else
            src = SRC_FILL;
    end

    assign wsStart = charTick && atomicMode && wsReq && !wsBusy
                     && !bistEn && parOk;

    logic [10:0] encOut;
    logic [9:0]  charNxt;
    logic        rdNxt;
    always_comb
    begin
        encOut = '0;
        case (src)
            SRC_DATA:    encOut = stxEncode(cur.txData, 1'b0, rd_r);
            SRC_FILL:    encOut = stxEncode(K28_5_DAT, 1'b1, rd_r);
            SRC_SPECIAL: encOut = stxEncode({cur.txData[7:5], K28_LOW5},
                                            1'b1, rd_r);
            SRC_BIST:    encOut = stxEncode(lfsr_r[7:0], 1'b0, rd_r);
            default:     encOut = {rd_r, 10'h000};
        endcase
        rdNxt   = encOut[10];
        charNxt = encOut[9:0];
        if (src == SRC_RAW)
            charNxt = {cur.txControlBits, cur.txData};
        else if (src == SRC_VIOL)
        begin
            rdNxt = rd_r;
            if (!encEn)
                charNxt = C07_POS;
            else
                charNxt = rd_r ? C07_NEG : C07_POS;
        end
    end

    // encoder state, sequences and output character
    logic       parErr_r;
    logic [9:0] shift_r;
    always_ff @(posedge core_clk or negedge rstN)
    begin
        if (!rstN)
        begin
            rd_r         <= 1'b0;
            wsCnt_r      <= 5'h00;
            lfsr_r       <= BIST_SEED;
            txCharOut    <= 10'h000;
            txCharStrobe <= 1'b0;
            parErr_r     <= 1'b0;
        end
        else
        begin
            txCharStrobe <= charTick;
            if (!bistEn)
                lfsr_r <= BIST_SEED;
            if (charTick)
            begin
                txCharOut <= charNxt;
                rd_r      <= rdNxt;
                parErr_r  <= !parOk && !bufErr_r && !bistEn && !wsBusy;
                if (bistEn)
                    lfsr_r <= {lfsr_r[7:0], lfsr_r[8] ^ lfsr_r[4]};
                if (wsStart)
                    wsCnt_r <= 5'(WSYNC_LEN - 1);
                else if (wsBusy)
                    wsCnt_r <= wsCnt_r - 5'h01;
            end
        end
    end

    // shifter, first bit out is bit 0
    always_ff @(posedge core_clk or negedge rstN)
    begin
        if (!rstN)
        begin
            shift_r     <= 10'h000;
            serialOut   <= 1'b0;
            txErrorFlag <= 1'b0;
        end
        else
        begin
            txErrorFlag <= bufErr_r || parErr_r;
            if (txCharStrobe)
            begin
                serialOut <= txCharOut[0];
                shift_r   <= {1'b0, txCharOut[9:1]};
            end
            else
            begin
                serialOut <= shift_r[0];
                shift_r   <= {1'b0, shift_r[9:1]};
            end
        end
    end

    // register bus write side: address and data taken in either order
    logic [7:0]  awAddr_r;
    logic [31:0] wData_r;
    logic [3:0]  wStrb_r;
    logic        wrGo;
    assign wrGo = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
    always_ff @(posedge core_clk or negedge rstN)
    begin
        if (!rstN)
        begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= RESP_OKAY;
            awAddr_r      <= 8'h00;
            wData_r       <= 32'h0000_0000;
            wStrb_r       <= 4'h0;
        end
        else
        begin
            if (s_axi_awready && s_axi_awvalid)
            begin
                awAddr_r      <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wready && s_axi_wvalid)
            begin
                wData_r      <= s_axi_wdata;
                wStrb_r      <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (wrGo)
            begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (awAddr_r == REG_CTRL) ? RESP_OKAY
                                                       : RESP_DECERR;
            end
            if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rstN)
    begin
        if (!rstN)
            ctrl_r <= CTRL_RESET;
        else if (wrGo && awAddr_r == REG_CTRL)
        begin
            if (wStrb_r[0])
                ctrl_r[7:0] <= wData_r[7:0];
            if (wStrb_r[1])
                ctrl_r[9:8] <= wData_r[9:8];
        end
    end

    // register bus read side
    always_ff @(posedge core_clk or negedge rstN)
    begin
        if (!rstN)
        begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= RESP_OKAY;
        end
        else if (s_axi_arready && s_axi_arvalid)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rresp   <= RESP_OKAY;
            case (s_axi_araddr)
                REG_CTRL:   s_axi_rdata <= {22'h000000, ctrl_r};
                REG_STATUS: s_axi_rdata <= {{(28 - PW){1'b0}}, fill,
                                            wsBusy, rd_r, parErr_r,
                                            bufErr_r};
                REG_CHAR:   s_axi_rdata <= {22'h000000, txCharOut};
                default:
                begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= RESP_DECERR;
                end
            endcase
        end
        else if (s_axi_rvalid && s_axi_rready)
        begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end
endmodule

// >>> test/stx_tx_input_path_chk.sv
// bus and line checks for the transmit input path
`timescale 1ns/10ps
module stx_tx_input_path_chk
    import stx_pkg::*;
(
    // clock and reset
    input wire logic        core_clk,
    input wire logic        resetn,
    // register bus
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    // line side
    input wire logic        txErrorFlag,
    input wire logic        serialOut,
    input wire logic [9:0]  txCharOut,
    input wire logic        txCharStrobe
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!resetn);
    property p_wr;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
            |=> ##1 s_axi_bvalid;
    endproperty
    property p_bhold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    property p_bbusy;
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
    endproperty
    property p_rd;
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
    endproperty
    property p_rdec;
        s_axi_rvalid && s_axi_rresp == RESP_DECERR |-> s_axi_rdata == 32'h0;
    endproperty
    property p_gap;
        txCharStrobe |=> !txCharStrobe [*8];
    endproperty
    property p_bit0;
        txCharStrobe |=> serialOut == txCharOut[0];
    endproperty
    property p_bits;
        txCharStrobe |=> ##1 serialOut == txCharOut[1]
            ##7 serialOut == txCharOut[8];
    endproperty
    property p_hold;
        txCharStrobe |=> $stable(txCharOut) [*7];
    endproperty
    property p_viol;
        // flag lags the character; held over two samples it is this one's
        txCharStrobe && txErrorFlag ##1 txErrorFlag
            |-> txCharOut inside {C07_POS, C07_NEG};
    endproperty
    a_wr:    assert property (p_wr) else $error("no write response");
    a_bhold: assert property (p_bhold) else $error("write response dropped");
    a_bbusy: assert property (p_bbusy) else $error("write taken while busy");
    a_rd:    assert property (p_rd) else $error("no read response");
    a_rdec:  assert property (p_rdec) else $error("unmapped read data");
    a_gap:   assert property (p_gap) else $error("character period short");
    a_bit0:  assert property (p_bit0) else $error("first bit wrong");
    a_bits:  assert property (p_bits) else $error("bit order wrong");
    a_hold:  assert property (p_hold) else $error("character unstable");
    a_viol:  assert property (p_viol) else $error("error without C0.7");
    c_wr:  cover property (s_axi_bvalid && s_axi_bready);
    c_dec: cover property (s_axi_rvalid && s_axi_rresp == RESP_DECERR);
    c_err: cover property (txCharStrobe && txErrorFlag);
endmodule

bind stx_tx_input_path stx_tx_input_path_chk u_chk (.core_clk, .resetn,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .txErrorFlag, .serialOut, .txCharOut, .txCharStrobe);

// >>> test/stx_host_model.sv
// host model: characters with parity, input clock and buffer reset
`timescale 1ns/10ps
module stx_host_model
    import stx_pkg::*;
(
    // bench control
    input wire logic      core_clk,
    input wire stx_char_s ch,
    input wire logic      fullPar,
    input wire logic      badPar,
    input wire logic      runClk,
    input wire logic      rstReq,
    // device pins
    output stx_char_s     txHostIn,
    output logic          txInputClock,
    output logic          alignBufferResetN
);
    logic [3:0] div = 4'h0;
    logic [2:0] rstCnt = 3'h0;
    logic       clk = 1'b0;
    always_comb
    begin
        txHostIn = ch;
        txHostIn.txParityBit = ~(^ch.txData ^ (fullPar & ^ch.txControlBits))
            ^ badPar;
    end
    // clock stands still while stopped, one rise per character
    always_ff @(posedge core_clk)
    begin
        div <= (div == 4'h4) ? 4'h0 : div + 4'h1;
        if (runClk && div == 4'h4)
            clk <= ~clk;
    end
    assign txInputClock = clk;
    // low for four edges, more than the two needed
    always_ff @(posedge core_clk)
        rstCnt <= rstReq ? 3'h4 : (rstCnt != 3'h0) ? rstCnt - 3'h1 : 3'h0;
    assign alignBufferResetN = (rstCnt == 3'h0);
endmodule

// >>> test/stx_tx_input_path_bench.sv
// self-checking bench for the transmit input path
`timescale 1ns/10ps
module stx_tx_input_path_bench;
    import stx_pkg::*;
    logic        core_clk = 1'b0, resetn = 1'b0;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, d, p;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic        arvalid = 1'b0, rready = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp, r;
    stx_char_s   ch = '0, txHostIn;
    logic        fullPar = 1'b0, badPar = 1'b0, runClk = 1'b0, rstReq = 1'b0;
    logic        txInputClock, alignBufferResetN, txErrorFlag, serialOut;
    logic        txCharStrobe;
    logic [9:0]  txCharOut, c1;
    int          n_errors = 0, comparisons = 0, seed = 41234, i;

    stx_tx_input_path dut (.core_clk, .resetn, .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .txHostIn, .txInputClock, .alignBufferResetN,
        .txErrorFlag, .serialOut, .txCharOut, .txCharStrobe);
    stx_host_model host (.core_clk, .ch, .fullPar, .badPar, .runClk,
        .rstReq, .txHostIn, .txInputClock, .alignBufferResetN);

    initial
    begin
        forever #4 core_clk = ~core_clk;
    end

    task automatic report_and_stop;
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic timeout;
        n_errors++;
        $display("mismatch at %0t: wait expired", $time);
        report_and_stop();
    endtask
    task automatic check(input logic ok, input string m);
        comparisons++;
        if (ok !== 1'b1)
        begin
            n_errors++;
            $display("mismatch at %0t: %s", $time, m);
        end
    endtask
    task automatic axw(input logic [7:0] a, input logic [31:0] v);
        int k;
        @(posedge core_clk);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (k = 0; k < 50 && !(bvalid === 1'b1 && k > 0); k++)
        begin
            @(posedge core_clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end
        if (k == 50) timeout();
        r = bresp;
        bready <= 1'b0;
    endtask
    task automatic axr(input logic [7:0] a);
        int k;
        @(posedge core_clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (k = 0; k < 50 && !(rvalid === 1'b1 && k > 0); k++)
        begin
            @(posedge core_clk);
            if (arready) arvalid <= 1'b0;
        end
        if (k == 50) timeout();
        r = rresp;
        d = rdata;
        rready <= 1'b0;
    endtask
    task automatic chars(input int n);
        int k;
        for (k = 0; n > 0 && k < 3000; k++)
        begin
            @(posedge core_clk);
            #1;
            if (txCharStrobe === 1'b1) n--;
        end
        if (n > 0) timeout();
    endtask
    task automatic expc(input logic [9:0] a, b, input string m);
        chars(5);
        check(txCharOut === a || txCharOut === b, m);
    endtask
    function automatic logic [9:0] exp_byp(input logic [31:0] v);
        return (v[0] & v[1]) ? C07_POS : {v[17:16], v[15:8]};
    endfunction

    initial
    begin
        repeat (12) @(posedge core_clk);
        resetn <= 1'b1;
        repeat (3) @(posedge core_clk);
        axr(REG_CTRL);
        check(d[9:0] === CTRL_RESET && r === RESP_OKAY, "ctrl reset");
        axr(8'h40);
        check(r === RESP_DECERR, "unmapped read");
        axw(8'h40, 32'h0);
        check(r === RESP_DECERR, "unmapped write");
        for (i = 0; i < 16; i++)
        begin
            p = $random(seed);
            axw(REG_CTRL, {26'h0, p[0] ? SEL_MID : SEL_LOW, 4'h0});
            ch <= {p[15:8], p[17:16], 2'b00};
            fullPar <= 1'b1;
            badPar <= p[0] & p[1];
            expc(exp_byp(p), exp_byp(p), "bypass char");
            check(txErrorFlag === (p[0] & p[1]), "parity flag");
        end
        fullPar <= 1'b0;
        badPar <= 1'b0;
        ch <= {8'h00, 2'b01, 2'b00};
        axw(REG_CTRL, 32'h10);
        expc(C07_POS, C07_POS, "bypass all bits");
        ch <= {8'hBC, 2'b10, 2'b00};
        axw(REG_CTRL, 32'h16);
        expc(10'h15C, 10'h163, "encoded data");
        axw(REG_CTRL, 32'h26);
        expc(C07_POS, C07_NEG, "encoded parity");
        axw(REG_CTRL, 32'h06);
        badPar <= 1'b1;
        expc(10'h15C, 10'h163, "parity off");
        ch <= {8'hFC, 2'b01, 2'b00};
        expc(10'h07C, 10'h383, "select ignored");
        axw(REG_CTRL, 32'h04);
        expc(10'h17C, 10'h283, "fill char");
        ch <= {8'hFC, 2'b01, 2'b01};
        expc(10'h07C, 10'h383, "special code");
        ch <= {8'hBC, 2'b00, 2'b00};
        axw(REG_CTRL, 32'h204);
        chars(3);
        c1 = txCharOut;
        chars(1);
        check(txCharOut !== c1, "self-test");
        axw(REG_CTRL, 32'h40);
        runClk <= 1'b1;
        rstReq <= 1'b1;
        chars(1);
        rstReq <= 1'b0;
        expc(10'h0BC, 10'h0BC, "buffer path");
        axr(REG_CHAR);
        check(d[9:0] === 10'h0BC, "char register");
        axw(REG_CTRL, 32'h100);
        chars(8);
        axw(REG_CTRL, 32'h40);
        expc(C07_POS, C07_NEG, "overflow");
        check(txErrorFlag === 1'b1, "sticky error");
        axr(REG_STATUS);
        check(d[0] === 1'b1, "status error bit");
        rstReq <= 1'b1;
        chars(1);
        rstReq <= 1'b0;
        expc(10'h0BC, 10'h0BC, "buffer reset");
        check(txErrorFlag === 1'b0, "error cleared");
        runClk <= 1'b0;
        expc(C07_POS, C07_NEG, "underflow");
        runClk <= 1'b1;
        axw(REG_CTRL, 32'h44);
        ch <= {8'hBC, 2'b11, 2'b00};
        chars(6);
        ch <= {8'hBC, 2'b00, 2'b00};
        chars(20);
        ch <= {8'hBC, 2'b11, 2'b00};
        chars(6);
        ch <= {8'hBC, 2'b00, 2'b00};
        chars(40);
        check(txErrorFlag === 1'b0, "word sync recentre");
        check(txCharOut inside {10'h15C, 10'h163}, "data resumes");
        report_and_stop();
    end
endmodule
